//--- verilog/mtsi_pkg.sv
// Package for the machine timer and software-interrupt unit.
// Assumes a 32-bit AHB-Lite register bus on hclk.
package mtsi_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [11:0] OFS_TIME_LO = 12'h000;
  localparam logic [11:0] OFS_TIME_HI = 12'h004;
  localparam logic [11:0] OFS_CMP_LO = 12'h008;
  localparam logic [11:0] OFS_CMP_HI = 12'h00C;
  localparam logic [11:0] OFS_SOFT = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_MASK = 12'h018;
  localparam logic [63:0] TIME_RESET = 64'h0;
  localparam logic [63:0] CMP_RESET = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [63:0] TIME_STEP = 64'h1;
  localparam int STAT_TIMER_BIT = 0;
  localparam int STAT_SOFT_BIT = 1;
  localparam int SOFT_REQ_BIT = 0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [2:0] {
    MTSI_SEL_NONE, MTSI_SEL_TLO, MTSI_SEL_THI, MTSI_SEL_CLO,
    MTSI_SEL_CHI, MTSI_SEL_SOFT, MTSI_SEL_STAT, MTSI_SEL_MASK
  } mtsi_sel_type;
endpackage

//--- verilog/mtsi_reg_if.sv
// Register write channel between bus slave and timer core.
// Assumes a single clock domain.
interface mtsi_reg_if;
  logic wr;
  mtsi_pkg::mtsi_sel_type sel;
  logic [31:0] wdata;
  logic [63:0] time_val;
  logic [63:0] cmp_val;
  modport slave (output wr, output sel, output wdata,
    input time_val, input cmp_val);
  modport core (input wr, input sel, input wdata,
    output time_val, output cmp_val);
endinterface

//--- verilog/mtsi_core.sv
// Time counter and compare register.
// Assumes writes arrive through the register interface on hclk.
module mtsi_core import mtsi_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  mtsi_reg_if.core rif
);
  logic [63:0] time_ff;
  logic [63:0] cmp_ff;
  logic [63:0] nxt_time;

  always_comb begin
    nxt_time = time_ff + TIME_STEP;
    if (rif.wr && rif.sel == MTSI_SEL_TLO) begin
      nxt_time = {time_ff[63:32], rif.wdata};
    end
    if (rif.wr && rif.sel == MTSI_SEL_THI) begin
      nxt_time = {rif.wdata, time_ff[31:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_ff <= TIME_RESET;
    end else begin
      time_ff <= nxt_time;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_ff <= CMP_RESET;
    end else if (rif.wr && rif.sel == MTSI_SEL_CLO) begin
      cmp_ff[31:0] <= rif.wdata;
    end else if (rif.wr && rif.sel == MTSI_SEL_CHI) begin
      cmp_ff[63:32] <= rif.wdata;
    end
  end

  assign rif.time_val = time_ff;
  assign rif.cmp_val = cmp_ff;

  a_count_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(rif.wr && (rif.sel == MTSI_SEL_TLO || rif.sel == MTSI_SEL_THI))
    |=> time_ff == $past(time_ff) + TIME_STEP)
    else $error("time counter did not step by one");
endmodule

//--- verilog/mtsi_top.sv
// Machine timer and software-interrupt unit, AHB-Lite slave.
// Assumes one 40 MHz clock and word-only single transfers.
// Summary of operation
// - A 64-bit time counter is held and readable by software.
// - The time counter is zero after reset before counting.
// - The time counter adds one every clock, except in a cycle where a time word write loads it.
// - Reading the time words returns the running counter value.
// - Timer pending is high exactly while time >= compare.
// - Time and compare each appear as low and high 32-bit words.
// - A software-interrupt register is written to request an irq.
module mtsi_top import mtsi_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic timer_irq,
  output logic soft_irq,
  output logic irq
);
  mtsi_reg_if rif ();

  logic wr_pend_ff;
  logic rd_pend_ff;
  mtsi_sel_type sel_ff;
  logic [31:0] hrdata_ff;
  logic timer_irq_ff;
  logic soft_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic irq_ff;
  logic take;
  mtsi_sel_type dec_sel;
  logic [63:0] nxt_time_view;
  logic nxt_timer;
  logic [1:0] nxt_status;
  logic [1:0] clr;
  logic [1:0] nxt_mask;
  logic hready_ff;
  logic hresp_ff;

  function automatic mtsi_sel_type decode(input logic [31:0] a);
    mtsi_sel_type s;
    s = MTSI_SEL_NONE;
    unique case (a[11:0])
      OFS_TIME_LO: s = MTSI_SEL_TLO;
      OFS_TIME_HI: s = MTSI_SEL_THI;
      OFS_CMP_LO: s = MTSI_SEL_CLO;
      OFS_CMP_HI: s = MTSI_SEL_CHI;
      OFS_SOFT: s = MTSI_SEL_SOFT;
      OFS_STATUS: s = MTSI_SEL_STAT;
      OFS_MASK: s = MTSI_SEL_MASK;
      default: s = MTSI_SEL_NONE;
    endcase
    return s;
  endfunction

  // Only word transfers are served; other sizes are ignored and leave hrdata as it was
  assign take = hsel && hready && htrans[1] && hsize == HSIZE_WORD;
  assign dec_sel = decode(haddr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      sel_ff <= MTSI_SEL_NONE;
    end else if (hready) begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      sel_ff <= take ? dec_sel : MTSI_SEL_NONE;
    end
  end

  // Write takes effect at the end of the data phase
  assign rif.wr = wr_pend_ff;
  assign rif.sel = sel_ff;
  assign rif.wdata = hwdata;

  mtsi_core i_mtsi_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .rif(rif)
  );

  // Read data is sampled in the address phase so it is zero-wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0;
    end else if (take && !hwrite) begin
      unique case (dec_sel)
        MTSI_SEL_TLO: hrdata_ff <= rif.time_val[31:0];
        MTSI_SEL_THI: hrdata_ff <= rif.time_val[63:32];
        MTSI_SEL_CLO: hrdata_ff <= rif.cmp_val[31:0];
        MTSI_SEL_CHI: hrdata_ff <= rif.cmp_val[63:32];
        MTSI_SEL_SOFT: hrdata_ff <= {31'h0, soft_ff};
        MTSI_SEL_STAT: hrdata_ff <= {30'h0, status_ff};
        MTSI_SEL_MASK: hrdata_ff <= {30'h0, mask_ff};
        MTSI_SEL_NONE: hrdata_ff <= 32'h0;
      endcase
    end
  end

  // Zero wait and always OKAY, yet still launched from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;

  // Counter value one cycle ahead, so the pending flag is registered
  // yet still exact: it tracks the compare in the same cycle.
  always_comb begin
    nxt_time_view = rif.time_val + TIME_STEP;
    if (rif.wr && rif.sel == MTSI_SEL_TLO) begin
      nxt_time_view = {rif.time_val[63:32], rif.wdata};
    end
    if (rif.wr && rif.sel == MTSI_SEL_THI) begin
      nxt_time_view = {rif.wdata, rif.time_val[31:0]};
    end
  end

  always_comb begin
    nxt_timer = nxt_time_view >= rif.cmp_val;
    if (rif.wr && rif.sel == MTSI_SEL_CLO) begin
      nxt_timer = nxt_time_view >= {rif.cmp_val[63:32], rif.wdata};
    end
    if (rif.wr && rif.sel == MTSI_SEL_CHI) begin
      nxt_timer = nxt_time_view >= {rif.wdata, rif.cmp_val[31:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq_ff <= 1'b0;
    end else begin
      timer_irq_ff <= nxt_timer;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_ff <= 1'b0;
    end else if (rif.wr && rif.sel == MTSI_SEL_SOFT) begin
      soft_ff <= hwdata[SOFT_REQ_BIT];
    end
  end

  assign timer_irq = timer_irq_ff;
  assign soft_irq = soft_ff;

  // Sticky events: the rising of each request; set wins over clear
  always_comb begin
    clr = 2'h0;
    if (rif.wr && rif.sel == MTSI_SEL_STAT) begin
      clr = hwdata[1:0];
    end
    nxt_status = status_ff & ~clr;
    if (nxt_timer && !timer_irq_ff) begin
      nxt_status[STAT_TIMER_BIT] = 1'b1;
    end
    if (rif.wr && rif.sel == MTSI_SEL_SOFT && hwdata[SOFT_REQ_BIT]
        && !soft_ff) begin
      nxt_status[STAT_SOFT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= 2'h0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Mask is looked ahead as well, so irq never lags a mask write
  always_comb begin
    nxt_mask = mask_ff;
    if (rif.wr && rif.sel == MTSI_SEL_MASK) begin
      nxt_mask = hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff <= 2'h0;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & nxt_mask);
    end
  end

  assign irq = irq_ff;

  a_pend_match: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_irq == (rif.time_val >= rif.cmp_val))
    else $error("timer pending does not match compare");

  a_soft_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rif.wr && rif.sel == MTSI_SEL_SOFT
    |=> soft_irq == $past(hwdata[SOFT_REQ_BIT]))
    else $error("soft request did not follow written bit");

  a_soft_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(rif.wr && rif.sel == MTSI_SEL_SOFT) |=> $stable(soft_irq))
    else $error("soft request changed without a write");

  a_time_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_TLO
    |=> hrdata == $past(rif.time_val[31:0]))
    else $error("time low read returned wrong value");

  a_cmp_hi_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_CHI
    |=> hrdata == $past(rif.cmp_val[63:32]))
    else $error("compare high read returned wrong value");

  a_time_mono: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rif.wr ##1 !rif.wr |-> rif.time_val > $past(rif.time_val))
    else $error("time counter did not increase");

  a_reset_zero: assert property (@(posedge hclk)
    $rose(hresetn) |-> rif.time_val <= 64'h1)
    else $error("time counter not cleared at reset");

  a_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(status_ff & mask_ff))
    else $error("interrupt does not match unmasked status");

  a_time_hi_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_THI
    |=> hrdata == $past(rif.time_val[63:32]))
    else $error("time high read returned wrong value");

  a_cmp_lo_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_CLO
    |=> hrdata == $past(rif.cmp_val[31:0]))
    else $error("compare low read returned wrong value");

  a_soft_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_SOFT
    |=> hrdata == {31'h0, $past(soft_irq)})
    else $error("soft register read returned wrong value");

  a_stat_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_STAT
    |=> hrdata == {30'h0, $past(status_ff)})
    else $error("status read returned wrong value");

  a_mask_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_MASK
    |=> hrdata == {30'h0, $past(mask_ff)})
    else $error("mask read returned wrong value");

  a_none_read: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && dec_sel == MTSI_SEL_NONE |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero data");

  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_tlo_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rif.wr && rif.sel == MTSI_SEL_TLO
    |=> rif.time_val[31:0] == $past(hwdata))
    else $error("time low write did not load");

  a_thi_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rif.wr && rif.sel == MTSI_SEL_THI
    |=> rif.time_val[63:32] == $past(hwdata))
    else $error("time high write did not load");

  a_clo_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rif.wr && rif.sel == MTSI_SEL_CLO
    |=> rif.cmp_val[31:0] == $past(hwdata))
    else $error("compare low write did not load");

  a_chi_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rif.wr && rif.sel == MTSI_SEL_CHI
    |=> rif.cmp_val[63:32] == $past(hwdata))
    else $error("compare high write did not load");

  a_cmp_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(rif.wr && (rif.sel == MTSI_SEL_CLO || rif.sel == MTSI_SEL_CHI))
    |=> $stable(rif.cmp_val))
    else $error("compare changed without a write");

  a_mask_load: assert property (@(posedge hclk) disable iff (!hresetn)
    rif.wr && rif.sel == MTSI_SEL_MASK |=> mask_ff == $past(hwdata[1:0]))
    else $error("mask write did not load");

  a_timer_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(timer_irq) |-> status_ff[STAT_TIMER_BIT])
    else $error("timer rise did not set status");

  a_soft_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(soft_irq) |-> status_ff[STAT_SOFT_BIT])
    else $error("soft rise did not set status");

  a_stat_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    !(rif.wr && rif.sel == MTSI_SEL_STAT)
    |=> (status_ff & $past(status_ff)) == $past(status_ff))
    else $error("status bit fell without a clear");

  a_ready_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave inserted wait or error");

  a_reset_quiet: assert property (
    @(posedge hclk)
    $rose(hresetn) |-> !timer_irq && !soft_irq && !irq)
    else $error("interrupt outputs not quiet after reset");

  a_one_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend_ff && rd_pend_ff))
    else $error("read and write pending together");
endmodule

//--- sim/mtsi_cpu_model.sv
// Processor-side bus master model: single word AHB-Lite transfers.
// Assumes one slave whose hreadyout is fed back as hready.
module mtsi_cpu_model import mtsi_pkg::*; (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  end

  // Caller enters just after a rising edge; no wait count is assumed
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

//--- sim/machine_timer_soft_interrupt_tb.sv
// Self-checking bench for the timer and software-interrupt unit.
// Assumes the bus model above drives the only AHB-Lite master port.
module machine_timer_soft_interrupt_tb import mtsi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic timer_irq;
  logic soft_irq;
  logic irq;
  logic [31:0] rd;
  logic [31:0] t0;
  int err_count = 0;
  int n_checks = 0;

  always #12.5 hclk = ~hclk;

  mtsi_top i_mtsi_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_irq(timer_irq),
    .soft_irq(soft_irq), .irq(irq));

  mtsi_cpu_model i_mtsi_cpu_model (.hclk(hclk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_mtsi_cpu_model.xfer(1'b1, a, d, rd);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] ex);
    i_mtsi_cpu_model.xfer(1'b0, a, 32'h0, rd);
    chk(nm, ex, rd);
  endtask

  // Outputs are registered, so let them settle before looking
  task automatic chki(input logic [2:0] ex);
    repeat (2) @(posedge hclk);
    chk("timer_soft_irq", {29'h0, ex}, {29'h0, timer_irq, soft_irq, irq});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("irqs after reset", 32'h0, {29'h0, timer_irq, soft_irq, irq});
    i_mtsi_cpu_model.xfer(1'b0, OFS_TIME_LO, 32'h0, t0);
    chk("time_lo near zero", 32'h1, {31'h0, t0 < 32'h10});
    rdc("time_lo step", OFS_TIME_LO, t0 + 32'h2);
    rdc("time_hi", OFS_TIME_HI, 32'h0);
    rdc("cmp_lo", OFS_CMP_LO, CMP_RESET[31:0]);
    rdc("cmp_hi", OFS_CMP_HI, CMP_RESET[63:32]);
    $display("test reset done");
    wr(OFS_TIME_HI, 32'h12);
    wr(OFS_TIME_LO, 32'hFFFFFFF0);
    repeat (20) @(posedge hclk);
    rdc("time_hi carry", OFS_TIME_HI, 32'h13);
    i_mtsi_cpu_model.xfer(1'b0, OFS_TIME_LO, 32'h0, t0);
    chk("time_lo wrapped", 32'h1, {31'h0, t0 < 32'h40});
    $display("test carry done");
    wr(OFS_CMP_HI, 32'h13);
    wr(OFS_CMP_LO, 32'h100);
    chki(3'b000);
    repeat (300) @(posedge hclk);
    chki(3'b100);
    rdc("status timer", OFS_STATUS, 32'h1);
    wr(OFS_MASK, 32'h3);
    chki(3'b101);
    wr(OFS_CMP_LO, 32'hFFFFFFFF);
    chki(3'b001);
    wr(OFS_STATUS, 32'h1);
    chki(3'b000);
    rdc("cmp_lo back", OFS_CMP_LO, 32'hFFFFFFFF);
    rdc("cmp_hi back", OFS_CMP_HI, 32'h13);
    $display("test compare done");
    wr(OFS_SOFT, 32'h1);
    chki(3'b011);
    rdc("status soft", OFS_STATUS, 32'h2);
    wr(OFS_SOFT, 32'h2);
    chki(3'b001);
    wr(OFS_STATUS, 32'h2);
    chki(3'b000);
    rdc("unmapped", 12'h01C, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    $display("test soft done");
    print_verdict();
  end
endmodule
